// [shared/bfls_regs.svh]
/*
  Constants of the bit/flag and load/store execution block: register
  offsets, command codes, flag positions, pointer pair indices, reset values.
  Assumes a 50 MHz aclk, 8-bit AXI4-Lite byte addresses, 32-bit data.
*/
// Operation
// - bit_to_flag_copy puts register bit in T, 1 cycle
// - flag_to_bit_copy writes T into bit, 1 cycle
// - overflow set/clear touches only V, 1 cycle
// - half-carry set/clear touches only H, 1 cycle
// - sign set/clear touches only S, 1 cycle
// - post-increment load reads then bumps pointer, 2 cycles
// - pre-decrement load drops pointer then reads, 2 cycles
// - displaced load reads pointer plus q, 2 cycles
// - direct load reads immediate address, 2 cycles
// - post-increment store writes then bumps pointer, 2 cycles
// - pre-decrement store drops pointer then writes, 2 cycles
// - displaced store writes pointer plus q, 2 cycles
`ifndef BFLS_REGS_SVH
`define BFLS_REGS_SVH

// register byte offsets
`define BFLS_OFF_CMD      8'h00
`define BFLS_OFF_IMM      8'h04
`define BFLS_OFF_STAT     8'h08
`define BFLS_OFF_FLAG     8'h0C
`define BFLS_RF_BIT       7
`define BFLS_RF_IDX_HI    6
`define BFLS_RF_IDX_LO    2

// status bits
`define BFLS_ST_BUSY      0
`define BFLS_ST_ERR       1

// reset values
`define BFLS_RST_REG      8'h00
`define BFLS_RST_FLAGS    8'h00

// flag positions in flag_register
`define BFLS_FLAG_T       6
`define BFLS_FLAG_H       5
`define BFLS_FLAG_S       4
`define BFLS_FLAG_V       3

// pointer pair select and low register index
`define BFLS_PTR_X        2'h0
`define BFLS_PTR_Y        2'h1
`define BFLS_PTR_Z        2'h2
`define BFLS_PTR_BAD      2'h3
`define BFLS_PTR_X_LO     5'h1A
`define BFLS_PTR_Y_LO     5'h1C
`define BFLS_PTR_Z_LO     5'h1E

// command codes
`define BFLS_OP_NOP       5'h00
`define BFLS_OP_B2F       5'h01
`define BFLS_OP_F2B       5'h02
`define BFLS_OP_OV_SET    5'h03
`define BFLS_OP_OV_CLR    5'h04
`define BFLS_OP_HC_SET    5'h05
`define BFLS_OP_HC_CLR    5'h06
`define BFLS_OP_SG_SET    5'h07
`define BFLS_OP_SG_CLR    5'h08
`define BFLS_OP_LD        5'h09
`define BFLS_OP_LD_POST   5'h0A
`define BFLS_OP_LD_PRE    5'h0B
`define BFLS_OP_LD_DISP   5'h0C
`define BFLS_OP_LD_DIR    5'h0D
`define BFLS_OP_ST        5'h0E
`define BFLS_OP_ST_POST   5'h0F
`define BFLS_OP_ST_PRE    5'h10
`define BFLS_OP_ST_DISP   5'h11
`define BFLS_OP_LAST      5'h11

// axi responses
`define BFLS_RESP_OKAY    2'h0
`define BFLS_RESP_SLVERR  2'h2

`endif

// [shared/bfls_pkg.sv]
/*
  Types of the bit/flag and load/store execution block.
  Assumes bfls_regs.svh supplies the numeric constants.
*/
`default_nettype none

package bfls_pkg;
    localparam int NUM_REGS = 32;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MEM} bfls_state_t;

    typedef struct packed {
        logic [1:0] rsv3;
        logic [5:0] disp;
        logic [1:0] rsv2;
        logic [1:0] ptr;
        logic       rsv1;
        logic [2:0] bitsel;
        logic [2:0] rsv0;
        logic [4:0] rsel;
        logic [2:0] rsv;
        logic [4:0] op;
    } bfls_cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } bfls_dmem_req_t;
endpackage : bfls_pkg

`default_nettype wire

// [core/bfls_core.sv]
/*
  Execution unit for flag/bit manipulation, indirect and displaced data
  transfers and direct loads, with its own 32 x 8 register file and flag
  register, commanded over AXI4-Lite.
  Assumes a data memory on aclk that returns dmem_rdata in the same cycle
  as a read strobe, and a single AXI4-Lite master.
*/
`include "bfls_regs.svh"
`default_nettype none

module bfls_core (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // data memory
    output bfls_pkg::bfls_dmem_req_t       dmem_req,
    input  wire logic [7:0]                dmem_rdata
);

    logic                      awready_ff;
    logic                      wready_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      arready_ff;
    logic                      rvalid_ff;
    logic [1:0]                rresp_ff;
    logic [31:0]               rdata_ff;
    logic [7:0]                waddr_ff;
    logic [31:0]               wdata_ff;
    logic [3:0]                wstrb_ff;
    bfls_pkg::bfls_cmd_t       cmd_ff;
    logic [15:0]               imm_ff;
    logic [7:0]                flags_ff;
    logic [7:0]                nxt_flags;
    logic                      err_ff;
    bfls_pkg::bfls_state_t     state_ff;
    bfls_pkg::bfls_state_t     nxt_state;
    bfls_pkg::bfls_dmem_req_t  dmem_req_ff;
    bfls_pkg::bfls_dmem_req_t  nxt_req;
    logic [7:0]                rf_ff [bfls_pkg::NUM_REGS];
    logic [7:0]                rf_wd [bfls_pkg::NUM_REGS];
    logic [bfls_pkg::NUM_REGS-1:0] rf_we;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign dmem_req      = dmem_req_ff;

    // write decode: acts once both address and data are held
    wire wr_fire   = !awready_ff && !wready_ff && !bvalid_ff;
    wire idle      = state_ff == bfls_pkg::ST_IDLE;
    wire wsel_cmd  = waddr_ff == `BFLS_OFF_CMD;
    wire wsel_imm  = waddr_ff == `BFLS_OFF_IMM;
    wire wsel_stat = waddr_ff == `BFLS_OFF_STAT;
    wire wsel_flag = waddr_ff == `BFLS_OFF_FLAG;
    wire wsel_rf   = waddr_ff[`BFLS_RF_BIT];
    wire wmapped   = wsel_cmd || wsel_imm || wsel_stat || wsel_flag || wsel_rf;
    wire [4:0] widx = waddr_ff[`BFLS_RF_IDX_HI:`BFLS_RF_IDX_LO];
    // state-changing writes while busy are dropped to keep operands stable
    wire bus_ok      = wr_fire && idle;
    wire bus_cmd_go  = bus_ok && wsel_cmd && (&wstrb_ff);
    wire bus_imm_wr  = bus_ok && wsel_imm;
    wire bus_flag_wr = bus_ok && wsel_flag && wstrb_ff[0];
    wire bus_rf_wr   = bus_ok && wsel_rf && wstrb_ff[0];

    // read decode
    wire rsel_cmd  = s_axi_araddr == `BFLS_OFF_CMD;
    wire rsel_imm  = s_axi_araddr == `BFLS_OFF_IMM;
    wire rsel_stat = s_axi_araddr == `BFLS_OFF_STAT;
    wire rsel_flag = s_axi_araddr == `BFLS_OFF_FLAG;
    wire rsel_rf   = s_axi_araddr[`BFLS_RF_BIT];
    wire rmapped   = rsel_cmd || rsel_imm || rsel_stat || rsel_flag || rsel_rf;
    wire [4:0] ridx = s_axi_araddr[`BFLS_RF_IDX_HI:`BFLS_RF_IDX_LO];
    wire [31:0] stat_word = ({31'h0000_0000, !idle} << `BFLS_ST_BUSY)
                          | ({31'h0000_0000, err_ff} << `BFLS_ST_ERR);
    wire [31:0] rd_mux = rsel_rf   ? {24'h00_0000, rf_ff[ridx]} :
                         rsel_cmd  ? cmd_ff :
                         rsel_imm  ? {16'h0000, imm_ff} :
                         rsel_stat ? stat_word :
                         rsel_flag ? {24'h00_0000, flags_ff} : 32'h0000_0000;

    // command decode
    wire [4:0] op      = cmd_ff.op;
    wire use_post      = op == `BFLS_OP_LD_POST || op == `BFLS_OP_ST_POST;
    wire use_pre       = op == `BFLS_OP_LD_PRE  || op == `BFLS_OP_ST_PRE;
    wire use_disp      = op == `BFLS_OP_LD_DISP || op == `BFLS_OP_ST_DISP;
    wire use_direct    = op == `BFLS_OP_LD_DIR;
    wire is_load       = (op >= `BFLS_OP_LD) && (op <= `BFLS_OP_LD_DIR);
    wire is_store      = (op >= `BFLS_OP_ST) && (op <= `BFLS_OP_LAST);
    wire is_mem        = is_load || is_store;
    // no displacement form on the first pair, and no fourth pair
    wire bad_op        = (op > `BFLS_OP_LAST)
                       || (is_mem && !use_direct && cmd_ff.ptr == `BFLS_PTR_BAD)
                       || (use_disp && cmd_ff.ptr == `BFLS_PTR_X);
    wire ok            = !bad_op;
    wire in_exec       = state_ff == bfls_pkg::ST_EXEC;
    wire in_mem        = state_ff == bfls_pkg::ST_MEM;

    // pointer pair as one 16-bit word so carries cross the byte boundary
    wire [4:0] ptr_lo  = (cmd_ff.ptr == `BFLS_PTR_Y) ? `BFLS_PTR_Y_LO :
                         (cmd_ff.ptr == `BFLS_PTR_Z) ? `BFLS_PTR_Z_LO : `BFLS_PTR_X_LO;
    wire [4:0] ptr_hi  = ptr_lo + 5'h01;
    wire [15:0] ptr_val = {rf_ff[ptr_hi], rf_ff[ptr_lo]};
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire [15:0] ptr_inc = ptr_val + 16'h0001;
    wire [15:0] mem_addr = use_direct ? imm_ff :
                           use_pre    ? ptr_dec :
                           use_disp   ? ptr_val + {10'h000, cmd_ff.disp} :
                                        ptr_val;
    wire ptr_we = ok && ((in_exec && use_pre) || (in_mem && use_post));
    wire [15:0] ptr_wv = in_exec ? ptr_dec : ptr_inc;

    // bit copy datapath
    wire [7:0] src      = rf_ff[cmd_ff.rsel];
    wire       src_bit  = src[cmd_ff.bitsel];
    wire [7:0] bit_mask = 8'h01 << cmd_ff.bitsel;
    wire [7:0] copied   = flags_ff[`BFLS_FLAG_T] ? (src | bit_mask) : (src & ~bit_mask);
    wire f2b_we = in_exec && op == `BFLS_OP_F2B;
    wire ld_we  = in_mem && is_load;
    wire [7:0] dst_val = in_mem ? dmem_rdata : copied;

    // sequencing: one-cycle ops finish in exec, transfers add the mem cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bfls_pkg::ST_IDLE: begin
                if (bus_cmd_go) begin
                    nxt_state = bfls_pkg::ST_EXEC;
                end
            end
            bfls_pkg::ST_EXEC: begin
                nxt_state = (is_mem && ok) ? bfls_pkg::ST_MEM : bfls_pkg::ST_IDLE;
            end
            bfls_pkg::ST_MEM: begin
                nxt_state = bfls_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = bfls_pkg::ST_IDLE;
            end
        endcase
    end

    // memory strobe stands for exactly the mem cycle
    always_comb begin
        nxt_req = '0;
        if (in_exec && ok && is_mem) begin
            nxt_req.addr  = mem_addr;
            nxt_req.wdata = src;
            nxt_req.we    = is_store;
            nxt_req.re    = is_load;
        end
    end

    // register file write ports; bus writes only land while idle
    always_comb begin
        rf_we = '0;
        for (int i = 0; i < bfls_pkg::NUM_REGS; i++) begin
            rf_wd[i] = rf_ff[i];
        end
        if (bus_rf_wr) begin
            rf_we[widx] = 1'b1;
            rf_wd[widx] = wdata_ff[7:0];
        end
        if (ptr_we) begin
            rf_we[ptr_lo] = 1'b1;
            rf_wd[ptr_lo] = ptr_wv[7:0];
            rf_we[ptr_hi] = 1'b1;
            rf_wd[ptr_hi] = ptr_wv[15:8];
        end
        // loaded byte wins if the destination is inside the pointer pair
        if (f2b_we || ld_we) begin
            rf_we[cmd_ff.rsel] = 1'b1;
            rf_wd[cmd_ff.rsel] = dst_val;
        end
    end

    // flag updates: B2F and each set/clear op touch their own flag; F2B, NOP and transfers none
    always_comb begin
        nxt_flags = flags_ff;
        if (bus_flag_wr) begin
            nxt_flags = wdata_ff[7:0];
        end
        if (in_exec && ok) begin
            case (op)
                `BFLS_OP_B2F:    nxt_flags[`BFLS_FLAG_T] = src_bit;
                `BFLS_OP_OV_SET: nxt_flags[`BFLS_FLAG_V] = 1'b1;
                `BFLS_OP_OV_CLR: nxt_flags[`BFLS_FLAG_V] = 1'b0;
                `BFLS_OP_HC_SET: nxt_flags[`BFLS_FLAG_H] = 1'b1;
                `BFLS_OP_HC_CLR: nxt_flags[`BFLS_FLAG_H] = 1'b0;
                `BFLS_OP_SG_SET: nxt_flags[`BFLS_FLAG_S] = 1'b1;
                `BFLS_OP_SG_CLR: nxt_flags[`BFLS_FLAG_S] = 1'b0;
                default: begin
                end
            endcase
        end
    end

    generate
        for (genvar g = 0; g < bfls_pkg::NUM_REGS; g++) begin : g_rf
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    rf_ff[g] <= `BFLS_RST_REG;
                end else if (rf_we[g]) begin
                    rf_ff[g] <= rf_wd[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff    <= bfls_pkg::ST_IDLE;
            flags_ff    <= `BFLS_RST_FLAGS;
            dmem_req_ff <= '0;
            err_ff      <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            flags_ff    <= nxt_flags;
            dmem_req_ff <= nxt_req;
            if (in_exec) begin
                err_ff <= bad_op;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ff <= '0;
            imm_ff <= 16'h0000;
        end else begin
            if (bus_cmd_go) begin
                cmd_ff <= wdata_ff;
            end
            if (bus_imm_wr && wstrb_ff[0]) begin
                imm_ff[7:0] <= wdata_ff[7:0];
            end
            if (bus_imm_wr && wstrb_ff[1]) begin
                imm_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `BFLS_RESP_OKAY;
            waddr_ff   <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                waddr_ff   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wmapped ? `BFLS_RESP_OKAY : `BFLS_RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // read channel: one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `BFLS_RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= rd_mux;
                rresp_ff   <= rmapped ? `BFLS_RESP_OKAY : `BFLS_RESP_SLVERR;
            end
            if (rvalid_ff && s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

endmodule : bfls_core

`default_nettype wire

// [tb/bfls_dmem_model.sv]
/*
  Behavioural data memory seen by bfls_core: 64K bytes, read data
  in the cycle of the read strobe, write at the edge ending the strobe.
  Assumes the request struct of bfls_pkg and the core's aclk.
*/
`default_nettype none

module bfls_dmem_model (
    // clock
    input  wire logic                     aclk,
    // request and answer
    input  wire bfls_pkg::bfls_dmem_req_t dmem_req,
    output logic [7:0]                    dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:65535];
    logic [7:0] last_ff;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
        end
        last_ff = 8'h00;
    end

    // off the strobe the line shows the inverse, so a late sample is caught
    assign dmem_rdata = dmem_req.re ? mem[dmem_req.addr] : ~last_ff;

    always @(posedge aclk) begin
        if (dmem_req.re) last_ff <= mem[dmem_req.addr];
        if (dmem_req.we) mem[dmem_req.addr] <= dmem_req.wdata;
    end
endmodule : bfls_dmem_model

`default_nettype wire

// [tb/bfls_core_checker.sv]
/*
  Timing checks on the data memory strobes of bfls_core.
  Assumes binding to bfls_core; sees its ports only.
*/
`default_nettype none

module bfls_core_checker (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // write answer
    input  wire logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // data memory
    input  wire bfls_pkg::bfls_dmem_req_t dmem_req
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_pulse: assert property (dmem_req.re |=> !dmem_req.re)
        else $error("read strobe longer than one cycle");
    a_write_pulse: assert property (dmem_req.we |=> !dmem_req.we)
        else $error("write strobe longer than one cycle");
    a_one_dir: assert property (!(dmem_req.re && dmem_req.we))
        else $error("read and write strobes together");
    a_quiet_bus: assert property (!(dmem_req.re || dmem_req.we) |-> dmem_req.addr == 16'h0000)
        else $error("address not zero outside access");
    // command lands at the edge raising bvalid, memory cycle is the second after
    a_mem_after_cmd: assert property ((dmem_req.re || dmem_req.we)
        |-> !$past(s_axi_bvalid, 2) && $past(s_axi_bvalid))
        else $error("memory cycle not second cycle after launch");
    a_mem_gap: assert property ((dmem_req.re || dmem_req.we) |=> !(dmem_req.re || dmem_req.we) [*2])
        else $error("memory cycles too close");
    a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_launch_quiet: assert property ($rose(s_axi_bvalid) |-> !(dmem_req.re || dmem_req.we))
        else $error("memory access at launch");
endmodule : bfls_core_checker

bind bfls_core bfls_core_checker u_bfls_core_checker (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .dmem_req     (dmem_req)
);

`default_nettype wire

// [tb/test_bfls_core.sv]
/*
  Self-checking bench for bfls_core: commands sent over AXI4-Lite,
  results read back from flags, register file and the memory model.
  Assumes bfls_dmem_model fills memory with addr lo ^ addr hi ^ 5A.
*/
`include "bfls_regs.svh"
`default_nettype none

module test_bfls_core;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     aclk, aresetn;
    logic [7:0]               awaddr, araddr;
    logic                     awvalid, awready, wvalid, wready, bvalid, bready;
    logic                     arvalid, arready, rvalid, rready;
    logic [31:0]              wdata, rdata;
    logic [3:0]               wstrb;
    logic [1:0]               bresp, rresp;
    bfls_pkg::bfls_dmem_req_t dmem_req;
    logic [7:0]               dmem_rdata;
    int                       error_cnt, compares;
    logic [4:0] fops [6] = '{`BFLS_OP_OV_SET, `BFLS_OP_HC_SET, `BFLS_OP_SG_SET,
                             `BFLS_OP_OV_CLR, `BFLS_OP_HC_CLR, `BFLS_OP_SG_CLR};
    logic [7:0] fexp [6] = '{8'h89, 8'hA9, 8'hB9, 8'hB1, 8'h91, 8'h81};

    bfls_core u_bfls_core (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata)
    );

    bfls_dmem_model u_bfls_dmem_model (.aclk(aclk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic close_out;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk({30'h0, bresp}, 32'h0);
                done = 1'b1;
            end
        end
        bready <= 1'b0;
        if (!done) begin
            chk(32'h0, 32'h1);
            close_out();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(rdata, exp);
                chk({30'h0, rresp}, {30'h0, er});
                done = 1'b1;
            end
        end
        rready <= 1'b0;
        if (!done) begin
            chk(32'h0, 32'h1);
            close_out();
        end
    endtask : rd

    function automatic logic [7:0] ra(input int i);
        return 8'h80 + 8'(4 * i);
    endfunction : ra

    function automatic logic [31:0] pat(input logic [15:0] a);
        return {24'h0, a[7:0] ^ a[15:8] ^ 8'h5A};
    endfunction : pat

    function automatic logic [31:0] cmd(input logic [4:0] op, input logic [4:0] r, input logic [2:0] b,
                                        input logic [1:0] p, input logic [5:0] q);
        bfls_pkg::bfls_cmd_t c;
        c        = '0;
        c.op     = op;
        c.rsel   = r;
        c.bitsel = b;
        c.ptr    = p;
        c.disp   = q;
        return c;
    endfunction : cmd

    // every command sent through exec is followed by a status read: idle and no error
    task automatic exec(input logic [31:0] c);
        wr(`BFLS_OFF_CMD, c);
        rd(`BFLS_OFF_STAT, 32'h0, `BFLS_RESP_OKAY);
    endtask : exec

    task automatic rq(input int i, input logic [7:0] v);
        rd(ra(i), {24'h0, v}, `BFLS_RESP_OKAY);
    endtask : rq

    initial begin
        error_cnt = 0;
        compares  = 0;
        {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BFLS_OFF_FLAG, 32'h0, `BFLS_RESP_OKAY);
        rd(8'h40, 32'h0, `BFLS_RESP_SLVERR);
        wr(`BFLS_OFF_FLAG, 32'h81);
        for (int i = 0; i < 6; i++) begin
            exec(cmd(fops[i], 5'h00, 3'h0, 2'h0, 6'h00));
            rd(`BFLS_OFF_FLAG, {24'h0, fexp[i]}, `BFLS_RESP_OKAY);
        end
        wr(ra(5), 32'h40);
        exec(cmd(`BFLS_OP_B2F, 5'd5, 3'd6, 2'h0, 6'h00));
        rd(`BFLS_OFF_FLAG, 32'hC1, `BFLS_RESP_OKAY);
        exec(cmd(`BFLS_OP_F2B, 5'd7, 3'd3, 2'h0, 6'h00));
        rq(7, 8'h08);
        rd(`BFLS_OFF_FLAG, 32'hC1, `BFLS_RESP_OKAY);
        exec(cmd(`BFLS_OP_B2F, 5'd5, 3'd0, 2'h0, 6'h00));
        rd(`BFLS_OFF_FLAG, 32'h81, `BFLS_RESP_OKAY);
        exec(cmd(`BFLS_OP_F2B, 5'd7, 3'd3, 2'h0, 6'h00));
        rq(7, 8'h00);
        wr(ra(26), 32'hFF);
        wr(ra(27), 32'h00);
        exec(cmd(`BFLS_OP_LD_POST, 5'd1, 3'h0, `BFLS_PTR_X, 6'h00));
        rd(ra(1), pat(16'h00FF), `BFLS_RESP_OKAY);
        rq(26, 8'h00);
        rq(27, 8'h01);
        exec(cmd(`BFLS_OP_LD_PRE, 5'd2, 3'h0, `BFLS_PTR_X, 6'h00));
        rd(ra(2), pat(16'h00FF), `BFLS_RESP_OKAY);
        rq(26, 8'hFF);
        rq(27, 8'h00);
        wr(ra(28), 32'h34);
        wr(ra(29), 32'h12);
        exec(cmd(`BFLS_OP_LD_DISP, 5'd3, 3'h0, `BFLS_PTR_Y, 6'd63));
        rd(ra(3), pat(16'h1273), `BFLS_RESP_OKAY);
        rq(28, 8'h34);
        wr(`BFLS_OFF_IMM, 32'hABCD);
        exec(cmd(`BFLS_OP_LD_DIR, 5'd4, 3'h0, 2'h0, 6'h00));
        rd(ra(4), pat(16'hABCD), `BFLS_RESP_OKAY);
        wr(ra(30), 32'h00);
        wr(ra(31), 32'h20);
        wr(ra(10), 32'hA5);
        wr(ra(11), 32'h3C);
        exec(cmd(`BFLS_OP_ST_POST, 5'd10, 3'h0, `BFLS_PTR_Z, 6'h00));
        chk({24'h0, u_bfls_dmem_model.mem[16'h2000]}, 32'hA5);
        rq(30, 8'h01);
        exec(cmd(`BFLS_OP_ST_PRE, 5'd11, 3'h0, `BFLS_PTR_Z, 6'h00));
        chk({24'h0, u_bfls_dmem_model.mem[16'h2000]}, 32'h3C);
        rq(30, 8'h00);
        exec(cmd(`BFLS_OP_ST_DISP, 5'd10, 3'h0, `BFLS_PTR_Y, 6'd5));
        chk({24'h0, u_bfls_dmem_model.mem[16'h1239]}, 32'hA5);
        rq(28, 8'h34);
        exec(cmd(`BFLS_OP_LD_DISP, 5'd12, 3'h0, `BFLS_PTR_Z, 6'd1));
        rd(ra(12), pat(16'h2001), `BFLS_RESP_OKAY);
        exec(cmd(`BFLS_OP_LD, 5'd13, 3'h0, `BFLS_PTR_Y, 6'h00));
        rd(ra(13), pat(16'h1234), `BFLS_RESP_OKAY);
        rq(28, 8'h34);
        exec(cmd(`BFLS_OP_ST, 5'd13, 3'h0, `BFLS_PTR_X, 6'h00));
        chk({24'h0, u_bfls_dmem_model.mem[16'h00FF]}, pat(16'h1234));
        rq(26, 8'hFF);
        // displacement on the first pair is refused: err set, nothing written
        wr(`BFLS_OFF_CMD, cmd(`BFLS_OP_LD_DISP, 5'd14, 3'h0, `BFLS_PTR_X, 6'd1));
        rd(`BFLS_OFF_STAT, 32'h2, `BFLS_RESP_OKAY);
        rq(14, 8'h00);
        // a plain no-op clears err again
        exec(cmd(`BFLS_OP_NOP, 5'd0, 3'h0, 2'h0, 6'h00));
        rd(`BFLS_OFF_FLAG, 32'h81, `BFLS_RESP_OKAY);
        close_out();
    end
endmodule : test_bfls_core

`default_nettype wire
